// ### hw/dup_pkg.sv
// dup_pkg: constants and carrier types for the host port block
// assumes: single 100 MHz core clock, all pins sampled by the core
package dup_pkg;
    // ------------------------------------------------------------
    // printer port register indices (two address lines)
    // ------------------------------------------------------------
    localparam logic [1:0] DUP_PP_DATA = 2'h0; // printer data latch
    localparam logic [1:0] DUP_PP_STAT = 2'h1; // printer status
    localparam logic [1:0] DUP_PP_CTRL = 2'h2; // printer control
    localparam logic [1:0] DUP_PP_IOSEL = 2'h3; // i/o select pattern
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int DUP_STAT_SEL_BIT = 3; // select-in level in status
    localparam int DUP_STAT_PE_BIT = 5; // paper-out in status
    localparam int DUP_STAT_ONL_BIT = 4; // on-line in status
    localparam int DUP_CTRL_SEL_BIT = 3; // select-in drive in control
    localparam int DUP_CTRL_DIR_BIT = 5; // direction bit in control
    // ------------------------------------------------------------
    // reset values and patterns
    // ------------------------------------------------------------
    localparam logic [7:0] DUP_RST_BYTE = 8'h00; // register reset value
    localparam logic [7:0] DUP_IOSEL_IN = 8'h55; // pattern: lines input
    localparam logic [7:0] DUP_IOSEL_OUT = 8'haa; // pattern: lines output
    // ------------------------------------------------------------
    // carrier types
    // ------------------------------------------------------------
    typedef struct packed {
        logic rd_n; // read strobe, active low
        logic wr_n; // write strobe, active low
        logic csa_n; // channel a select
        logic csb_n; // channel b select
        logic csp_n; // printer port select
        logic [2:0] addr; // register address lines
    } dup_host_t;
    typedef struct packed {
        logic paper_out; // paper-out input level
        logic online; // printer-online input level
        logic sel_in; // select-in pin level
        logic dir_src; // direction source select
    } dup_pstat_t;
endpackage

// ### hw/dup_sync.sv
// dup_sync: two-flop synchroniser for a bus of pin levels
// assumes: inputs asynchronous to core_clk_i
`timescale 1ns/1ps
module dup_sync #(
    parameter int W = 1
) (
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // levels
    input wire logic [W-1:0] d_i,
    output logic [W-1:0] q_o
);
    logic [W-1:0] meta; // first stage, read only by the second
    logic [W-1:0] stab; // second stage
    // ------------------------------------------------------------
    // two stages; reset value is a constant
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            meta <= '0;
            stab <= '0;
        end else begin
            meta <= d_i;
            stab <= meta;
        end
    end
    assign q_o = stab;
endmodule // dup_sync

// ### hw/dup_host_port.sv
// dup_host_port: host strobe decode, channel register banks and the
// printer port data, status and select-in pins.
// assumes: host pins are asynchronous; two-flop sync adds latency.
//
// Operation
// RQ1 - read strobe low drives selected register
// RQ2 - write strobe falling stores host data
// RQ3 - printer data latched, held until next write
// RQ4 - read-active high during device read
// RQ5 - reset clears registers and outputs; pp_out_mode resets to 1 (output)
// RQ6 - serial lines disabled during reset
// RQ7 - status bit 3 shows select-in level
// RQ8 - control bit 3 pulls select-in low
// RQ9 - paper-out input readable by host
// RQ10 - printer-online input readable by host
// RQ11 - host lowers one chip select
// RQ12 - direction source picks iosel or ctrl5
// RQ13 - data bus released without valid read
`timescale 1ns/1ps
module dup_host_port
    import dup_pkg::*;
(
    // clock and reset
    input wire logic core_clk_i,
    input wire logic nrst_i,
    // host bus
    input wire dup_pkg::dup_host_t host_i,
    input wire logic [7:0] host_data_bus_i,
    output logic [7:0] host_data_bus_o,
    output logic host_data_bus_oe_o,
    output logic read_active_out_o,
    // printer pins
    input wire logic [7:0] printer_data_lines_i,
    output logic [7:0] printer_data_lines_o,
    output logic printer_data_lines_oe_o,
    input wire logic paper_out_in_i,
    input wire logic printer_online_in_i,
    input wire logic printer_select_out_n_i,
    output logic printer_select_out_n_o,
    output logic printer_select_out_n_oe_o,
    input wire logic direction_source_sel_i,
    // serial enables toward the uart engines
    output logic serial_tx_en_o,
    output logic serial_rx_en_o
);
    import dup_pkg::*;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    localparam int SW = $bits(dup_host_t) + 8 + 8 + 4;
    logic [SW-1:0] raw_pins; // raw pin bundle
    logic [SW-1:0] syn_pins; // synchronised bundle
    dup_host_t hs; // synced host controls
    logic [7:0] hd; // synced host data
    logic [7:0] pd_in; // synced printer lines
    dup_pstat_t ps; // synced printer status pins

    assign raw_pins = {host_i, host_data_bus_i, printer_data_lines_i,
                       paper_out_in_i, printer_online_in_i,
                       printer_select_out_n_i, direction_source_sel_i};

    dup_sync #(.W(SW)) u_sync (
        .core_clk_i(core_clk_i),
        .nrst_i(nrst_i),
        .d_i(raw_pins),
        .q_o(syn_pins)
    );

    assign hs = syn_pins[SW-1 -: $bits(dup_host_t)];
    assign hd = syn_pins[19:12];
    assign pd_in = syn_pins[11:4];
    assign ps = syn_pins[3:0];

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    logic sel_a; // channel a selected
    logic sel_b; // channel b selected
    logic sel_p; // printer port selected
    logic any_sel; // exactly one select low
    logic rd_act; // read cycle in progress
    logic wr_low; // write strobe low with select
    logic wr_prev; // previous write strobe state
    logic wr_fall; // falling edge of write, one pulse

    assign sel_a = !hs.csa_n;
    assign sel_b = !hs.csb_n;
    assign sel_p = !hs.csp_n;
    // two selects together is a host fault; nothing answers then
    assign any_sel = (32'(sel_a) + 32'(sel_b) + 32'(sel_p)) == 32'd1; // RQ11
    assign rd_act = !hs.rd_n && any_sel;
    assign wr_low = !hs.wr_n && any_sel;
    assign wr_fall = wr_low && !wr_prev; // RQ2

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    logic [7:0] chan_a [8]; // channel a register bank
    logic [7:0] chan_b [8]; // channel b register bank
    logic [7:0] pp_data; // printer data latch
    logic [7:0] pp_ctrl; // printer control
    logic [7:0] pp_iosel; // i/o select pattern
    logic pp_out_mode; // iosel-driven direction, 1 = output
    logic [7:0] next_chan_a [8];
    logic [7:0] next_chan_b [8];
    logic [7:0] next_pp_data;
    logic [7:0] next_pp_ctrl;
    logic [7:0] next_pp_iosel;
    logic next_pp_out_mode;

    // next state of the writable registers
    always_comb begin
        next_chan_a = chan_a;
        next_chan_b = chan_b;
        next_pp_data = pp_data;
        next_pp_ctrl = pp_ctrl;
        next_pp_iosel = pp_iosel;
        next_pp_out_mode = pp_out_mode;
        if (wr_fall) begin
            if (sel_a) begin
                next_chan_a[hs.addr] = hd; // RQ2
            end else if (sel_b) begin
                next_chan_b[hs.addr] = hd; // RQ2
            end else begin
                // printer port uses only the low two lines
                unique case (hs.addr[1:0])
                    DUP_PP_DATA: next_pp_data = hd; // RQ3
                    DUP_PP_STAT: ; // status is read only
                    DUP_PP_CTRL: next_pp_ctrl = hd;
                    DUP_PP_IOSEL: begin
                        next_pp_iosel = hd;
                        // only the two patterns change direction
                        if (hd == DUP_IOSEL_OUT) begin
                            next_pp_out_mode = 1'b1;
                        end else if (hd == DUP_IOSEL_IN) begin
                            next_pp_out_mode = 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // register the bank; reset clears everything except pp_out_mode, which resets to 1 (output)
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            for (int i = 0; i < 8; i++) begin
                chan_a[i] <= DUP_RST_BYTE; // RQ5
                chan_b[i] <= DUP_RST_BYTE; // RQ5
            end
            pp_data <= DUP_RST_BYTE; // RQ5
            pp_ctrl <= DUP_RST_BYTE;
            pp_iosel <= DUP_RST_BYTE;
            pp_out_mode <= 1'b1;
            wr_prev <= 1'b0;
        end else begin
            chan_a <= next_chan_a;
            chan_b <= next_chan_b;
            pp_data <= next_pp_data;
            pp_ctrl <= next_pp_ctrl;
            pp_iosel <= next_pp_iosel;
            pp_out_mode <= next_pp_out_mode;
            wr_prev <= wr_low;
        end
    end

    // ------------------------------------------------------------
    // direction and read mux
    // ------------------------------------------------------------
    logic pd_drive; // printer lines driven by device
    logic [7:0] status_byte; // printer status value
    logic [7:0] rd_byte; // selected read value

    // direction source: pattern register or control bit 5
    assign pd_drive = ps.dir_src ? !pp_ctrl[DUP_CTRL_DIR_BIT]
                                 : pp_out_mode; // RQ12

    // status: pins as seen on the wire
    always_comb begin
        status_byte = 8'h00;
        status_byte[DUP_STAT_SEL_BIT] = ps.sel_in; // RQ7
        status_byte[DUP_STAT_PE_BIT] = ps.paper_out; // RQ9
        status_byte[DUP_STAT_ONL_BIT] = ps.online; // RQ10
    end

    // read source selection
    always_comb begin
        rd_byte = 8'h00;
        if (sel_a) begin
            rd_byte = chan_a[hs.addr]; // RQ1
        end else if (sel_b) begin
            rd_byte = chan_b[hs.addr]; // RQ1
        end else begin
            unique case (hs.addr[1:0])
                // in input mode the data register reads the pins
                DUP_PP_DATA: rd_byte = pd_drive ? pp_data : pd_in;
                DUP_PP_STAT: rd_byte = status_byte;
                DUP_PP_CTRL: rd_byte = pp_ctrl;
                DUP_PP_IOSEL: rd_byte = pp_iosel;
            endcase
        end
    end

    // ------------------------------------------------------------
    // output registers
    // ------------------------------------------------------------
    logic [7:0] next_dout;
    logic next_doe;
    logic next_read_active_out;

    // outputs computed here, registered below
    always_comb begin
        next_dout = rd_act ? rd_byte : 8'h00; // RQ1
        next_doe = rd_act; // RQ13
        next_read_active_out = rd_act; // RQ4
    end

    // every output straight from a flop
    always_ff @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            host_data_bus_o <= 8'h00;
            host_data_bus_oe_o <= 1'b0; // RQ13
            read_active_out_o <= 1'b0; // RQ5
            printer_data_lines_o <= 8'h00;
            printer_data_lines_oe_o <= 1'b0;
            printer_select_out_n_o <= 1'b0;
            printer_select_out_n_oe_o <= 1'b0; // RQ5
            serial_tx_en_o <= 1'b0; // RQ6
            serial_rx_en_o <= 1'b0; // RQ6
        end else begin
            host_data_bus_o <= next_dout;
            host_data_bus_oe_o <= next_doe;
            read_active_out_o <= next_read_active_out;
            printer_data_lines_o <= pp_data; // RQ3
            printer_data_lines_oe_o <= pd_drive;
            // open drain: only ever pulls low
            printer_select_out_n_o <= 1'b0;
            printer_select_out_n_oe_o <= pp_ctrl[DUP_CTRL_SEL_BIT]; // RQ8
            serial_tx_en_o <= 1'b1;
            serial_rx_en_o <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    property p_read_drives;
        @(posedge core_clk_i) disable iff (!nrst_i)
        rd_act |=> host_data_bus_oe_o && host_data_bus_o == $past(rd_byte);
    endproperty
    a_read_drives: assert property (p_read_drives) // RQ1
        else $error("read did not drive data bus");

    property p_write_store;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (wr_fall && sel_a) |=> chan_a[$past(hs.addr)] == $past(hd);
    endproperty
    a_write_store: assert property (p_write_store) // RQ2
        else $error("write not stored in channel a");

    property p_pd_hold;
        @(posedge core_clk_i) disable iff (!nrst_i)
        !(wr_fall && sel_p) |=> pp_data == $past(pp_data);
    endproperty
    a_pd_hold: assert property (p_pd_hold) // RQ3
        else $error("printer data changed without write");

    property p_read_active_out;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ##1 read_active_out_o == $past(rd_act);
    endproperty
    a_read_active_out: assert property (p_read_active_out) // RQ4
        else $error("read active wrong");

    property p_serial_en;
        @(posedge core_clk_i)
        !nrst_i |-> !serial_tx_en_o && !serial_rx_en_o;
    endproperty
    a_serial_en: assert property (p_serial_en) // RQ6
        else $error("serial enabled in reset");

    property p_sel_drive;
        @(posedge core_clk_i) disable iff (!nrst_i)
        ##1 printer_select_out_n_oe_o == $past(pp_ctrl[DUP_CTRL_SEL_BIT])
            && !printer_select_out_n_o;
    endproperty
    a_sel_drive: assert property (p_sel_drive) // RQ8
        else $error("select-in drive wrong");

    // checked at the bus, so a wrong mux leg is caught too
    property p_status;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (rd_act && sel_p && hs.addr[1:0] == DUP_PP_STAT) |=>
            host_data_bus_o[DUP_STAT_SEL_BIT] == $past(ps.sel_in)
            && host_data_bus_o[DUP_STAT_PE_BIT] == $past(ps.paper_out)
            && host_data_bus_o[DUP_STAT_ONL_BIT] == $past(ps.online);
    endproperty
    a_status: assert property (p_status) // RQ7
        else $error("status does not reflect pins");

    property p_release;
        @(posedge core_clk_i) disable iff (!nrst_i)
        (hs.rd_n || !any_sel) |=> !host_data_bus_oe_o;
    endproperty
    a_release: assert property (p_release) // RQ13
        else $error("data bus driven without read");

    c_read: cover property (@(posedge core_clk_i) rd_act ##1 !rd_act);
    c_pwrite: cover property (@(posedge core_clk_i) wr_fall && sel_p);
    c_dirbit: cover property (@(posedge core_clk_i) ps.dir_src && pd_drive);
endmodule // dup_host_port

// ### tb/dup_printer_model.sv
// dup_printer_model: behavioural printer and wire-or party at the pins
// assumes: printer drives its data lines only while the device does not
`timescale 1ns/1ps
module dup_printer_model (
    // device side of the pins
    input wire logic [7:0] dev_data_i,
    input wire logic dev_data_oe_i,
    input wire logic sel_n_i,
    input wire logic sel_oe_i,
    // printer behaviour set by the bench
    input wire logic [7:0] drive_i,
    input wire logic pe_i,
    input wire logic onl_i,
    input wire logic ext_pull_i,
    // resolved pin levels
    output logic [7:0] lines_o,
    output logic sel_wire_o,
    output logic pe_o,
    output logic onl_o
);
    // --------------------------------------------------------------
    // pin resolution
    // --------------------------------------------------------------
    // the printer backs off whenever the device owns the data lines
    assign lines_o = dev_data_oe_i ? dev_data_i : drive_i;
    // open drain with pull-up: any party pulling low wins
    assign sel_wire_o = ~((sel_oe_i & ~sel_n_i) | ext_pull_i);
    // status inputs, levels straight from the printer
    assign pe_o = pe_i;
    assign onl_o = onl_i;
endmodule // dup_printer_model

// ### tb/dup_host_port_tb.sv
// dup_host_port_tb: self-checking bench for the host port block
// assumes: bench acts as host cpu, printer model on the far pins
`timescale 1ns/1ps
module dup_host_port_tb;
    import dup_pkg::*;
    // --------------------------------------------------------------
    // signals
    // --------------------------------------------------------------
    // reset starts released so that its first assertion is a real edge
    logic core_clk_i = 1'b0, nrst_i = 1'b1, dir_sel = 1'b0;
    dup_host_t host = '1; // strobes and selects idle high
    logic [7:0] hd_i = 8'h00, hd_o, pd_o, pd_lines, pdrv = 8'h00;
    logic hd_oe, ra, pd_oe, sel_n, sel_oe, sel_wire, pe, onl;
    logic pe_d = 1'b1, onl_d = 1'b1, ext = 1'b0, tx_en, rx_en, prev_ra;
    logic [15:0] exp_q[$]; // {mask, expected byte}
    logic [7:0] bank_a[8], bank_b[8];
    int fail_count = 0, checked = 0, cycles = 0;
    // --------------------------------------------------------------
    // instances
    // --------------------------------------------------------------
    dup_host_port u_dup_host_port (.core_clk_i(core_clk_i),
        .nrst_i(nrst_i), .host_i(host), .host_data_bus_i(hd_i),
        .host_data_bus_o(hd_o), .host_data_bus_oe_o(hd_oe),
        .read_active_out_o(ra), .printer_data_lines_i(pd_lines),
        .printer_data_lines_o(pd_o), .printer_data_lines_oe_o(pd_oe),
        .paper_out_in_i(pe), .printer_online_in_i(onl),
        .printer_select_out_n_i(sel_wire),
        .printer_select_out_n_o(sel_n),
        .printer_select_out_n_oe_o(sel_oe),
        .direction_source_sel_i(dir_sel),
        .serial_tx_en_o(tx_en), .serial_rx_en_o(rx_en));
    dup_printer_model u_dup_printer_model (.dev_data_i(pd_o),
        .dev_data_oe_i(pd_oe), .sel_n_i(sel_n), .sel_oe_i(sel_oe),
        .drive_i(pdrv), .pe_i(pe_d), .onl_i(onl_d), .ext_pull_i(ext),
        .lines_o(pd_lines), .sel_wire_o(sel_wire), .pe_o(pe),
        .onl_o(onl));
    // --------------------------------------------------------------
    // clock, timeout and helpers
    // --------------------------------------------------------------
    initial begin
        forever #5 core_clk_i = ~core_clk_i;
    end
    // a hang is cut off well past the expected run of ~780 cycles
    always @(posedge core_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            close_out();
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_i);
        #1;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        if (fail_count == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    // one access: selects cs = {printer, b, a}, held 6 cycles
    task automatic acc(input logic w, input logic [2:0] cs,
                       input logic [2:0] a, input logic [7:0] d);
        host.addr = a;
        {host.csp_n, host.csb_n, host.csa_n} = ~cs;
        hd_i = d;
        host.wr_n = ~w;
        host.rd_n = w;
        cyc(6);
        host = '1;
        hd_i = ~d; // stale bus value changes once released
        cyc(6);
        check({6'h00, hd_oe, ra}, 8'h00);
    endtask
    task automatic rd(input logic [2:0] cs, input logic [2:0] a,
                      input logic [7:0] exp, input logic [7:0] m);
        exp_q.push_back({m, exp});
        acc(1'b0, cs, a, 8'h00);
    endtask
    // reset checks: output enables and read-active quiet, serial paths held off
    task automatic do_reset();
        nrst_i = 1'b0;
        cyc(2);
        check({2'h0, hd_oe, ra, pd_oe, sel_oe, tx_en, rx_en}, 8'h00);
        check({6'h00, tx_en, rx_en}, 8'h00);
        nrst_i = 1'b1;
        cyc(4);
        check({6'h00, tx_en, rx_en}, 8'h03);
    endtask
    // --------------------------------------------------------------
    // output watcher: each rise of read-active takes the oldest note
    // --------------------------------------------------------------
    always @(posedge core_clk_i) begin
        logic [15:0] e;
        #2;
        if (ra === 1'b1 && prev_ra !== 1'b1) begin
            if (exp_q.size() == 0) begin
                check(8'hff, 8'h00);
            end else begin
                e = exp_q.pop_front();
                check(hd_o & e[15:8], e[7:0] & e[15:8]);
                check({7'h00, hd_oe}, 8'h01);
            end
        end
        prev_ra = ra;
    end
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial begin
        logic [7:0] v;
        void'($urandom(32'hb789));
        // reset before the first edge, so no flop is ever clocked unknown
        #1;
        do_reset();
        // both channel banks, every address, random bytes
        for (int i = 0; i < 8; i++) begin
            bank_a[i] = 8'($urandom());
            bank_b[i] = 8'($urandom());
            acc(1'b1, 3'b001, 3'(i), bank_a[i]);
            acc(1'b1, 3'b010, 3'(i), bank_b[i]);
        end
        for (int i = 0; i < 8; i++) begin
            rd(3'b001, 3'(i), bank_a[i], 8'hff);
            rd(3'b010, 3'(i), bank_b[i], 8'hff);
        end
        // two selects at once: refused both ways
        acc(1'b1, 3'b011, 3'h2, ~bank_a[2]);
        acc(1'b0, 3'b011, 3'h2, 8'h00);
        rd(3'b001, 3'h2, bank_a[2], 8'hff);
        // printer data latched in output mode, held over other writes
        v = 8'($urandom());
        acc(1'b1, 3'b100, {1'b0, DUP_PP_DATA}, v);
        acc(1'b1, 3'b001, 3'h0, ~v);
        check(pd_o, v);
        check({7'h00, pd_oe}, 8'h01);
        // pattern control, then control bit 5 control
        pdrv = 8'($urandom());
        acc(1'b1, 3'b100, {1'b0, DUP_PP_IOSEL}, DUP_IOSEL_IN);
        check({7'h00, pd_oe}, 8'h00);
        rd(3'b100, {1'b0, DUP_PP_DATA}, pdrv, 8'hff);
        acc(1'b1, 3'b100, {1'b0, DUP_PP_IOSEL}, 8'h12);
        check({7'h00, pd_oe}, 8'h00);
        acc(1'b1, 3'b100, {1'b0, DUP_PP_CTRL}, 8'h00);
        check({7'h00, pd_oe}, 8'h00);
        acc(1'b1, 3'b100, {1'b0, DUP_PP_IOSEL}, DUP_IOSEL_OUT);
        check({7'h00, pd_oe}, 8'h01);
        dir_sel = 1'b1;
        acc(1'b1, 3'b100, {1'b0, DUP_PP_CTRL}, 8'h20);
        check({7'h00, pd_oe}, 8'h00);
        acc(1'b1, 3'b100, {1'b0, DUP_PP_CTRL}, 8'h00);
        check({7'h00, pd_oe}, 8'h01);
        check(pd_o, v);
        // select-in drive, wired-or neighbour and status inputs
        for (int i = 0; i < 8; i++) begin
            pe_d = 1'($urandom());
            onl_d = 1'($urandom());
            // neighbour pulls while the device has released the pin
            ext = (i == 4);
            acc(1'b1, 3'b100, {1'b0, DUP_PP_CTRL}, {4'h0, i[0], 3'h0});
            check({7'h00, sel_oe}, {7'h00, i[0]});
            check({7'h00, sel_wire}, {7'h00, ~i[0] & ~ext});
            rd(3'b100, {1'b0, DUP_PP_STAT},
               {2'h0, pe_d, onl_d, ~i[0] & ~ext, 3'h0}, 8'h38);
        end
        // status is read only: a write must not reach the control bits
        acc(1'b1, 3'b100, {1'b0, DUP_PP_STAT}, 8'hff);
        check({7'h00, pd_oe}, 8'h01);
        check({7'h00, sel_oe}, 8'h01);
        // control bit 3 still set from the last pass, so the pin reads low
        rd(3'b100, {1'b0, DUP_PP_STAT}, {2'h0, pe_d, onl_d, 4'h0},
           8'h38);
        // reset in mid-run clears the banks
        do_reset();
        rd(3'b001, 3'h3, DUP_RST_BYTE, 8'hff);
        rd(3'b010, 3'h7, DUP_RST_BYTE, 8'hff);
        check(8'(exp_q.size()), 8'h00);
        close_out();
    end
endmodule // dup_host_port_tb
